/* File: ioie_map.svh */
// Opcode patterns, field positions and reset values of the execution block
`ifndef IOIE_MAP_SVH
`define IOIE_MAP_SVH

`define IOIE_OPC_MSB        13
`define IOIE_OPC_LSB        8
`define IOIE_LDL_MSB        13
`define IOIE_LDL_LSB        10
`define IOIE_DEST_BIT       7
`define IOIE_REG_MSB        6
`define IOIE_REG_LSB        0
`define IOIE_LIT_MSB        7
`define IOIE_LIT_LSB        0

`define IOIE_OPC_INC        6'h0A
`define IOIE_OPC_INCSZ      6'h0F
`define IOIE_OPC_IOR        6'h04
`define IOIE_OPC_LDL        4'hC

`define IOIE_DEST_ACC       1'h0
`define IOIE_ONE            8'h01
`define IOIE_ZERO           8'h00
`define IOIE_ACC_RST        8'h00
`define IOIE_ZFLAG_RST      1'h0

`endif

/* File: ioie_pkg.sv */
// Types shared by the execution block
package ioie_pkg;

	typedef logic [13:0] ioie_instr_t;
	typedef logic [7:0]  ioie_byte_t;
	typedef logic [6:0]  ioie_addr_t;

	typedef enum logic [1:0] {
		IOIE_ST_RUN   = 2'b01,
		IOIE_ST_FLUSH = 2'b10
	} ioie_state_e;

	typedef struct packed {
		logic       wr_en;
		ioie_addr_t wr_addr;
		ioie_byte_t wr_data;
	} ioie_wr_s;

	typedef struct packed {
		ioie_state_e st;
		ioie_byte_t  acc;
		logic        zflag;
		ioie_wr_s    wr;
		logic        skip;
		logic        discard;
		logic        done;
	} ioie_state_s;

endpackage

/* File: ioie_exec.sv */
// Execution of increment, increment-skip, OR and load-literal instructions
//
// Functional notes
// - Increment opcode adds one to the operand modulo 256 and updates zero flag.
// - Destination bit 0 writes the accumulator, 1 writes back the data register.
// - Increment-skip writes result, requests skip on zero, leaves flags alone.
// - On a skip the prefetched instruction is discarded and a no-op executes.
// - OR opcode ORs accumulator with operand, routes result, updates zero flag.
// - Load-literal copies the literal into the accumulator, flags untouched.
`timescale 1ns/1ps
`default_nettype none
`include "ioie_map.svh"

module ioie_exec (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	// Instruction from fetch stage
	input  wire logic             instr_valid_in,
	input  wire ioie_pkg::ioie_instr_t instr_in,
	// Operand read from data register file
	input  wire ioie_pkg::ioie_byte_t  reg_rdata_in,
	// Write-back to data register file
	output var  ioie_pkg::ioie_wr_s    reg_wr_out,
	// Core state
	output var  ioie_pkg::ioie_byte_t  acc_out,
	output var  logic             zflag_out,
	// Sequencing
	output var  logic             skip_out,
	output var  logic             discard_out,
	output var  logic             done_out
);
	import ioie_pkg::*;

	ioie_state_s s;
	ioie_state_s next_s;

	logic       exec;
	logic [5:0] opc;
	logic       op_inc;
	logic       op_incsz;
	logic       op_ior;
	logic       op_ldl;
	logic       op_file;
	logic       dest_reg;
	ioie_byte_t inc_res;
	ioie_byte_t or_res;
	ioie_byte_t res;
	logic       res_zero;

	// Operand read is assumed combinational from the instruction address
	assign exec     = instr_valid_in && (s.st == IOIE_ST_RUN);
	assign opc      = instr_in[`IOIE_OPC_MSB:`IOIE_OPC_LSB];
	assign op_inc   = (opc == `IOIE_OPC_INC);
	assign op_incsz = (opc == `IOIE_OPC_INCSZ);
	assign op_ior   = (opc == `IOIE_OPC_IOR);
	assign op_ldl   = (instr_in[`IOIE_LDL_MSB:`IOIE_LDL_LSB] == `IOIE_OPC_LDL);
	assign op_file  = op_inc || op_incsz || op_ior;
	assign dest_reg = (instr_in[`IOIE_DEST_BIT] != `IOIE_DEST_ACC);
	assign inc_res  = 8'(reg_rdata_in + `IOIE_ONE);
	assign or_res   = s.acc | reg_rdata_in;
	assign res      = op_ior ? or_res : inc_res;
	assign res_zero = (res == `IOIE_ZERO);

	always_comb begin
		next_s         = s;
		next_s.wr.wr_en = 1'b0;
		next_s.skip    = 1'b0;
		next_s.discard = 1'b0;
		next_s.done    = 1'b0;
		case (s.st)
			IOIE_ST_FLUSH: begin
				// Prefetched word is dropped; waits for it if fetch stalls
				if (instr_valid_in) begin
					next_s.discard = 1'b1;
					next_s.st      = IOIE_ST_RUN;
				end
			end
			IOIE_ST_RUN: begin
				if (instr_valid_in && op_file) begin
					next_s.done = 1'b1;
					if (dest_reg) begin
						next_s.wr.wr_en   = 1'b1;
						next_s.wr.wr_addr = instr_in[`IOIE_REG_MSB:`IOIE_REG_LSB];
						next_s.wr.wr_data = res;
					end else begin
						next_s.acc = res;
					end
					if (op_inc || op_ior) begin
						next_s.zflag = res_zero;
					end
					if (op_incsz && res_zero) begin
						next_s.skip = 1'b1;
						next_s.st   = IOIE_ST_FLUSH;
					end
				end else if (instr_valid_in && op_ldl) begin
					next_s.done = 1'b1;
					next_s.acc  = instr_in[`IOIE_LIT_MSB:`IOIE_LIT_LSB];
				end
			end
			default: begin
				next_s.st = IOIE_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s.st         <= IOIE_ST_RUN;
			s.acc        <= `IOIE_ACC_RST;
			s.zflag      <= `IOIE_ZFLAG_RST;
			s.wr.wr_en   <= 1'b0;
			s.wr.wr_addr <= '0;
			s.wr.wr_data <= '0;
			s.skip       <= 1'b0;
			s.discard    <= 1'b0;
			s.done       <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign reg_wr_out  = s.wr;
	assign acc_out     = s.acc;
	assign zflag_out   = s.zflag;
	assign skip_out    = s.skip;
	assign discard_out = s.discard;
	assign done_out    = s.done;

	default clocking ioie_cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	property p_inc_wrap;
		exec && op_inc && !dest_reg && (reg_rdata_in == 8'hFF)
			|=> (acc_out == 8'h00) && zflag_out;
	endproperty
	a_inc_wrap: assert property (p_inc_wrap)
		else $error("increment did not wrap to zero with flag set");

	property p_dest_acc;
		exec && op_file && !dest_reg
			|=> (acc_out == $past(res)) && !reg_wr_out.wr_en;
	endproperty
	a_dest_acc: assert property (p_dest_acc)
		else $error("accumulator destination not honoured");

	property p_dest_reg;
		exec && op_file && dest_reg
			|=> reg_wr_out.wr_en && $stable(acc_out)
			&& (reg_wr_out.wr_addr == $past(instr_in[6:0]))
			&& (reg_wr_out.wr_data == $past(res));
	endproperty
	a_dest_reg: assert property (p_dest_reg)
		else $error("register write-back wrong");

	property p_incsz_flags;
		exec && op_incsz |=> $stable(zflag_out);
	endproperty
	a_incsz_flags: assert property (p_incsz_flags)
		else $error("increment-skip changed the zero flag");

	property p_skip_req;
		exec && op_incsz |=> (skip_out == $past(res_zero));
	endproperty
	a_skip_req: assert property (p_skip_req)
		else $error("skip request does not match zero result");

	property p_flush;
		skip_out && instr_valid_in
			|=> discard_out && !done_out && !reg_wr_out.wr_en
			&& $stable(acc_out) && $stable(zflag_out) ##1 !discard_out;
	endproperty
	a_flush: assert property (p_flush)
		else $error("prefetched instruction not squashed as no-op");

	// Squash must survive fetch stalls, else the word after a skip would run
	property p_flush_wait;
		(s.st == IOIE_ST_FLUSH) && !instr_valid_in
			|=> (s.st == IOIE_ST_FLUSH) && !discard_out && !done_out
			&& !reg_wr_out.wr_en && $stable(acc_out) && $stable(zflag_out);
	endproperty
	a_flush_wait: assert property (p_flush_wait)
		else $error("flush not held while fetch stalled");

	property p_ior_flag;
		exec && op_ior |=> (zflag_out == ($past(or_res) == 8'h00));
	endproperty
	a_ior_flag: assert property (p_ior_flag)
		else $error("OR zero flag wrong");

	property p_inc_flag;
		exec && op_inc |=> (zflag_out == ($past(inc_res) == 8'h00));
	endproperty
	a_inc_flag: assert property (p_inc_flag)
		else $error("increment zero flag wrong");

	property p_ldl;
		exec && op_ldl
			|=> (acc_out == $past(instr_in[7:0])) && $stable(zflag_out)
			&& !reg_wr_out.wr_en;
	endproperty
	a_ldl: assert property (p_ldl)
		else $error("literal load wrong");

	property p_cov_skip;
		exec && op_incsz && res_zero ##1 instr_valid_in ##1 discard_out;
	endproperty
	c_cov_skip: cover property (p_cov_skip);

	property p_cov_ior_wb;
		exec && op_ior && dest_reg;
	endproperty
	c_cov_ior_wb: cover property (p_cov_ior_wb);

	property p_cov_ldl_inc;
		exec && op_ldl ##1 exec && op_inc && !dest_reg;
	endproperty
	c_cov_ldl_inc: cover property (p_cov_ldl_inc);

	property p_cov_skip_stall;
		skip_out && !instr_valid_in ##1 instr_valid_in ##1 discard_out;
	endproperty
	c_cov_skip_stall: cover property (p_cov_skip_stall);

endmodule // ioie_exec
`default_nettype wire

/* File: ioie_regfile.sv */
// Data register file model seen by the execution block
`timescale 1ns/1ps
`default_nettype none
module ioie_regfile (
	// Clock
	input  wire logic                  clk_in,
	// Address and write-back from the core
	input  wire ioie_pkg::ioie_instr_t instr_in,
	input  wire ioie_pkg::ioie_wr_s    reg_wr_in,
	// Operand
	output var  ioie_pkg::ioie_byte_t  reg_rdata_out
);
	import ioie_pkg::*;
	ioie_byte_t mem [0:127];
	initial begin
		for (int i = 0; i < 128; i++) mem[i] = 8'h00;
	end
	// Read is combinational because the core has no read address port
	assign reg_rdata_out = mem[instr_in[6:0]];
	always @(posedge clk_in) begin
		if (reg_wr_in.wr_en) begin
			mem[reg_wr_in.wr_addr] <= reg_wr_in.wr_data;
		end
	end
endmodule // ioie_regfile
`default_nettype wire

/* File: tb_increment_or_instruction_exec.sv */
// Self-checking bench for the execution block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(16'(g), 16'(e))
module tb_increment_or_instruction_exec;
	import ioie_pkg::*;
	logic        clk_in, rst_b_in, instr_valid_in;
	ioie_instr_t instr_in;
	ioie_byte_t  reg_rdata_in, acc_out;
	ioie_wr_s    reg_wr_out;
	logic        zflag_out, skip_out, discard_out, done_out;
	int          miscompares = 0;
	int          n_checks = 0;
	int          cycles = 0;
	ioie_exec i_ioie_exec (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.instr_valid_in(instr_valid_in), .instr_in(instr_in),
		.reg_rdata_in(reg_rdata_in), .reg_wr_out(reg_wr_out),
		.acc_out(acc_out), .zflag_out(zflag_out), .skip_out(skip_out),
		.discard_out(discard_out), .done_out(done_out));
	ioie_regfile i_ioie_regfile (.clk_in(clk_in), .instr_in(instr_in),
		.reg_wr_in(reg_wr_out), .reg_rdata_out(reg_rdata_in));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Valid stays high so back-to-back words need no extra edge
	task automatic issue(input ioie_instr_t w);
		instr_valid_in = 1'b1;
		instr_in = w;
		@(posedge clk_in);
		#1;
	endtask
	task automatic idle();
		instr_valid_in = 1'b0;
		@(posedge clk_in);
		#1;
	endtask
	task automatic t_inc();
		i_ioie_regfile.mem[5] = 8'hFF;
		i_ioie_regfile.mem[6] = 8'h7F;
		issue(14'h0A85);
		`CHK(done_out, 1'b1);
		`CHK(reg_wr_out, {1'b1, 7'h05, 8'h00});
		`CHK(zflag_out, 1'b1);
		issue(14'h0A06);
		`CHK(acc_out, 8'h80);
		`CHK(reg_wr_out.wr_en, 1'b0);
		`CHK(zflag_out, 1'b0);
		idle();
		`CHK(i_ioie_regfile.mem[5], 8'h00);
		$display("test increment finished");
	endtask
	task automatic t_or();
		i_ioie_regfile.mem[7] = 8'h13;
		issue(14'h3391);
		`CHK(acc_out, 8'h91);
		issue(14'h0407);
		`CHK(acc_out, 8'h93);
		`CHK(zflag_out, 1'b0);
		issue(14'h3000);
		`CHK(acc_out, 8'h00);
		`CHK(zflag_out, 1'b0);
		issue(14'h0488);
		`CHK(reg_wr_out, {1'b1, 7'h08, 8'h00});
		`CHK(zflag_out, 1'b1);
		idle();
		$display("test or and literal finished");
	endtask
	task automatic t_skip();
		i_ioie_regfile.mem[9] = 8'hFF;
		i_ioie_regfile.mem[10] = 8'h01;
		issue(14'h0A06);
		`CHK(zflag_out, 1'b0);
		issue(14'h0F09);
		`CHK({skip_out, done_out, acc_out}, 10'h300);
		`CHK(zflag_out, 1'b0);
		issue(14'h3077);
		`CHK({discard_out, done_out, acc_out}, 10'h200);
		issue(14'h0F8A);
		`CHK({discard_out, skip_out}, 2'b00);
		`CHK(reg_wr_out, {1'b1, 7'h0A, 8'h02});
		issue(14'h3044);
		`CHK(acc_out, 8'h44);
		issue(14'h2BFF);
		`CHK({done_out, reg_wr_out.wr_en, acc_out}, 10'h044);
		idle();
		$display("test skip finished");
	endtask
	task automatic t_skip_stall();
		i_ioie_regfile.mem[11] = 8'hFF;
		issue(14'h0F8B);
		`CHK(reg_wr_out, {1'b1, 7'h0B, 8'h00});
		`CHK({skip_out, done_out, acc_out}, 10'h344);
		`CHK(zflag_out, 1'b0);
		idle();
		`CHK({discard_out, done_out, acc_out}, 10'h044);
		`CHK(i_ioie_regfile.mem[11], 8'h00);
		issue(14'h3055);
		`CHK({discard_out, done_out, acc_out}, 10'h244);
		issue(14'h3055);
		`CHK({discard_out, done_out, acc_out}, 10'h155);
		idle();
		$display("test skip across stall finished");
	endtask
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			wrap_up();
		end
	end
	initial begin
		rst_b_in = 1'b0;
		instr_valid_in = 1'b0;
		instr_in = 14'h0000;
		repeat (2) @(posedge clk_in);
		#1;
		rst_b_in = 1'b1;
		`CHK({acc_out, zflag_out}, 9'h000);
		t_inc();
		t_or();
		t_skip();
		t_skip_stall();
		wrap_up();
	end
endmodule // tb_increment_or_instruction_exec
`default_nettype wire
